//--- pkg/dram_pkg.sv
// Constants and types of the DRAM space access controller.
package dram_pkg;
  localparam logic [7:0] MEM_CTRL_OFS   = 8'h00;
  localparam logic [7:0] BUS_CTRL1_OFS  = 8'h04;
  localparam logic [7:0] BUS_CTRL3_OFS  = 8'h08;
  localparam logic [7:0] WAIT_CTRL1_OFS = 8'h0C;
  localparam logic [7:0] WAIT_CTRL2_OFS = 8'h10;
  localparam logic [7:0] STAT_OFS       = 8'h14;
  localparam int MEM_CTRL_W  = 10;
  localparam int MC_TRP      = 0;
  localparam int MC_RCD      = 1;
  localparam int MC_AMX      = 3;
  localparam int MC_MUX_RSVD = 5;
  localparam int MC_BURST    = 6;
  localparam int MC_ROW_HELD = 7;
  localparam int MC_EDO      = 8;
  localparam int MC_SZ32     = 9;
  localparam logic [9:0] MEM_CTRL_RST   = 10'h000;
  localparam logic [2:0] BUS_CTRL1_RST  = 3'h0;
  localparam logic [1:0] BUS_CTRL3_RST  = 2'h0;
  localparam logic [1:0] WAIT_CTRL1_RST = 2'h0;
  localparam logic       WAIT_CTRL2_RST = 1'b0;
  localparam logic [2:0] TYPE_DRAM = 3'h2;
  localparam logic [1:0] WAIT_EXTRA_MAX = 2'h2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE, ST_PRE, ST_PRE_W, ST_ROW, ST_ROW_W, ST_DMA_W, ST_COL, ST_CAP
  } state_t;
endpackage : dram_pkg

//--- hw/dram_addr_mux.sv
// Row and column multiplexer for the DRAM address outputs.
`timescale 1ns/100ps
module dram_addr_mux (
  input  wire logic [24:1] addr,
  input  wire logic        row_phase,
  input  wire logic [1:0]  column_width_select,
  output logic      [24:1] mux_addr
);
  always_comb begin
    mux_addr[24:16] = addr[24:16];
    mux_addr[15:1] = addr[15:1];
    if (row_phase) begin
      unique case (column_width_select)
        2'h0: mux_addr[15:1] = addr[23:9];
        2'h1: mux_addr[15:1] = addr[24:10];
        2'h2: mux_addr[15:1] = {1'b1, addr[24:11]};
        2'h3: mux_addr[15:1] = {2'h3, addr[24:12]};
      endcase
    end
  end
endmodule : dram_addr_mux

//--- hw/pin_sync.sv
// Three flip-flop synchroniser that accepts a change once stages agree.
`timescale 1ns/100ps
module pin_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin,
  output logic      level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sync_t;
  sync_t q;
  sync_t d;
  always_comb begin
    d = q;
    d.s1 = pin;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.s2 == q.s3) begin
      d.lvl = q.s3;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= 4'hF;
    end else begin
      q <= d;
    end
  end
  assign level = q.lvl;
endmodule : pin_sync

//--- hw/dram_space_access_controller.sv
// DRAM space access controller with its AXI4-Lite register slave.
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
module dram_space_access_controller (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic        req_write,
  input  wire logic        req_dma_single,
  input  wire logic [24:0] req_addr,
  input  wire logic [3:0]  req_byte_en,
  input  wire logic [31:0] req_wdata,
  output logic             done,
  output logic [31:0]      done_rdata,
  output logic [24:1]      dram_addr,
  output logic             row_strobe_n,
  output logic [3:0]       column_strobe_n,
  output logic             read_strobe_n,
  output logic             rd_wr_n,
  output logic             output_enable_n,
  output logic             dma_acknowledge_n,
  output logic             bus_start_strobe_n,
  output logic [31:0]      data_out,
  output logic             data_oe_n,
  input  wire logic [31:0] data_in,
  input  wire logic        ext_wait_n
);
  typedef struct packed {
    dram_pkg::state_t st;
    logic [1:0]       cnt;
    logic [9:0]       mem_ctrl;
    logic [2:0]       bus_ctrl1;
    logic [1:0]       bus_ctrl3;
    logic [1:0]       wait_ctrl1;
    logic             wait_ctrl2;
    logic             aw_hs;
    logic             w_hs;
    logic [7:0]       awaddr;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic             we;
    logic             dma;
    logic [24:0]      addr;
    logic [3:0]       lanes;
    logic [31:0]      wd;
    logic             row_open;
    logic [24:9]      open_row;
    logic             ack;
    logic [31:0]      rd;
  } regs_t;

  regs_t       q;
  regs_t       d;
  logic        wait_level;
  logic        enabled;
  logic        trp;
  logic [1:0]  rcd;
  logic [1:0]  amx;
  logic        burst;
  logic        row_held;
  logic        ext_data_out_select;
  logic        sz32;
  logic [1:0]  dsww;
  logic [1:0]  w3x;
  logic        ext_wait;
  logic        take;
  logic        same;
  logic        row_phase;
  logic        ras_act;
  logic        busy;
  logic [31:0] wm;

  pin_sync u_wait_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (ext_wait_n),
    .level   (wait_level)
  );

  dram_addr_mux u_addr_mux (
    .addr                (q.addr[24:1]),
    .row_phase           (row_phase),
    .column_width_select (amx),
    .mux_addr            (dram_addr)
  );

  assign enabled = q.bus_ctrl1 == dram_pkg::TYPE_DRAM;
  assign trp = q.mem_ctrl[dram_pkg::MC_TRP];
  assign rcd = q.mem_ctrl[dram_pkg::MC_RCD+:2];
  assign amx = q.mem_ctrl[dram_pkg::MC_AMX+:2];
  assign burst = q.mem_ctrl[dram_pkg::MC_BURST];
  assign row_held = q.mem_ctrl[dram_pkg::MC_ROW_HELD];
  assign ext_data_out_select = q.mem_ctrl[dram_pkg::MC_EDO];
  assign sz32 = q.mem_ctrl[dram_pkg::MC_SZ32];
  assign dsww = q.bus_ctrl3;
  // Field codes above the longest stretch saturate rather than wrap.
  assign w3x = (q.wait_ctrl1 > dram_pkg::WAIT_EXTRA_MAX) ?
               dram_pkg::WAIT_EXTRA_MAX : q.wait_ctrl1;
  // The mask wins over any wait field value.
  assign ext_wait = !q.wait_ctrl2 && (q.wait_ctrl1 != 2'h0)
                    && !wait_level;
  assign busy = q.st != dram_pkg::ST_IDLE;
  assign take = req_valid && req_ready;
  // Row compare covers only the bits that form the row slice.
  assign same = q.row_open && burst
                && (((req_addr[24:9] ^ q.open_row) >> amx)
                    == 16'h0000);

  function automatic logic [31:0] reg_val(input logic [7:0] a);
    reg_val = 32'h0000_0000;
    unique case (a)
      dram_pkg::MEM_CTRL_OFS:   reg_val[9:0] = q.mem_ctrl;
      dram_pkg::BUS_CTRL1_OFS:  reg_val[2:0] = q.bus_ctrl1;
      dram_pkg::BUS_CTRL3_OFS:  reg_val[1:0] = q.bus_ctrl3;
      dram_pkg::WAIT_CTRL1_OFS: reg_val[1:0] = q.wait_ctrl1;
      dram_pkg::WAIT_CTRL2_OFS: reg_val[0] = q.wait_ctrl2;
      dram_pkg::STAT_OFS: reg_val[4:0] = {ext_wait, q.row_open, q.st};
      default:            reg_val = 32'h0000_0000;
    endcase
  endfunction : reg_val

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == dram_pkg::MEM_CTRL_OFS)
             || (a == dram_pkg::BUS_CTRL1_OFS)
             || (a == dram_pkg::BUS_CTRL3_OFS)
             || (a == dram_pkg::WAIT_CTRL1_OFS)
             || (a == dram_pkg::WAIT_CTRL2_OFS)
             || (a == dram_pkg::STAT_OFS);
  endfunction : mapped

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[i*8+:8] = nw[i*8+:8];
      end
    end
  endfunction : merge

  // Column entry: DMA single writes first wait for the data setup.
  function automatic dram_pkg::state_t col_st(input logic dw);
    col_st = (dw && dsww != 2'h0) ? dram_pkg::ST_DMA_W
                                  : dram_pkg::ST_COL;
  endfunction : col_st

  function automatic logic [1:0] col_cnt(input logic dw);
    col_cnt = (dw && dsww != 2'h0) ? dsww - 2'h1 : w3x;
  endfunction : col_cnt

  always_comb begin
    d = q;
    d.ack = 1'b0;
    wm = merge(reg_val(q.awaddr), q.wdata, q.wstrb);
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_hs = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_hs = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (q.aw_hs && q.w_hs) begin
      d.aw_hs = 1'b0;
      d.w_hs = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = mapped(q.awaddr) ? dram_pkg::RESP_OKAY
                                 : dram_pkg::RESP_SLVERR;
      unique case (q.awaddr)
        dram_pkg::MEM_CTRL_OFS:   d.mem_ctrl = wm[9:0];
        dram_pkg::BUS_CTRL1_OFS:  d.bus_ctrl1 = wm[2:0];
        dram_pkg::BUS_CTRL3_OFS:  d.bus_ctrl3 = wm[1:0];
        dram_pkg::WAIT_CTRL1_OFS: d.wait_ctrl1 = wm[1:0];
        dram_pkg::WAIT_CTRL2_OFS: d.wait_ctrl2 = wm[0];
        default:            d.bvalid = 1'b1;
      endcase
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      d.rvalid = 1'b1;
      d.rdata = reg_val(s_axi_araddr);
      d.rresp = mapped(s_axi_araddr) ? dram_pkg::RESP_OKAY
                                     : dram_pkg::RESP_SLVERR;
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end

    unique case (q.st)
      dram_pkg::ST_IDLE: begin
        // Only row held mode with burst on keeps a row open while the port is idle.
        if (!(row_held && burst)) begin
          d.row_open = 1'b0;
        end
      end
      dram_pkg::ST_PRE: begin
        d.st = trp ? dram_pkg::ST_PRE_W : dram_pkg::ST_ROW;
      end
      dram_pkg::ST_PRE_W: begin
        d.st = dram_pkg::ST_ROW;
      end
      dram_pkg::ST_ROW: begin
        d.open_row = q.addr[24:9];
        if (rcd != 2'h0) begin
          d.st = dram_pkg::ST_ROW_W;
          d.cnt = rcd - 2'h1;
        end else begin
          d.st = col_st(q.we && q.dma);
          d.cnt = col_cnt(q.we && q.dma);
        end
      end
      dram_pkg::ST_ROW_W: begin
        if (q.cnt != 2'h0) begin
          d.cnt = q.cnt - 2'h1;
        end else begin
          d.st = col_st(q.we && q.dma);
          d.cnt = col_cnt(q.we && q.dma);
        end
      end
      dram_pkg::ST_DMA_W: begin
        if (q.cnt != 2'h0) begin
          d.cnt = q.cnt - 2'h1;
        end else begin
          d.st = dram_pkg::ST_COL;
          d.cnt = w3x;
        end
      end
      dram_pkg::ST_COL: begin
        if (q.cnt != 2'h0) begin
          d.cnt = q.cnt - 2'h1;
        end else if (!ext_wait) begin
          d.st = dram_pkg::ST_CAP;
          d.row_open = burst;
          if (!q.we && !ext_data_out_select) begin
            d.rd = data_in;
          end
        end
      end
      dram_pkg::ST_CAP: begin
        d.ack = 1'b1;
        // EXT_DATA_OUT_SELECT data stays valid after the column strobe, so it is
        // latched one edge later for a longer access window.
        if (!q.we && ext_data_out_select) begin
          d.rd = data_in;
        end
        d.st = dram_pkg::ST_IDLE;
        if (!(row_held && burst)) begin
          d.row_open = 1'b0;
        end
      end
    endcase

    if (take) begin
      d.we = req_write;
      d.dma = req_dma_single;
      d.addr = req_addr;
      d.lanes = req_byte_en;
      d.wd = req_wdata;
      if (same) begin
        d.row_open = 1'b1;
        d.st = col_st(req_write && req_dma_single);
        d.cnt = col_cnt(req_write && req_dma_single);
      end else if (q.row_open || q.st == dram_pkg::ST_IDLE) begin
        d.row_open = 1'b0;
        d.st = dram_pkg::ST_PRE;
      end else begin
        d.st = trp ? dram_pkg::ST_PRE_W
                   : dram_pkg::ST_ROW;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.mem_ctrl <= dram_pkg::MEM_CTRL_RST;
      q.bus_ctrl1 <= dram_pkg::BUS_CTRL1_RST;
      q.bus_ctrl3 <= dram_pkg::BUS_CTRL3_RST;
      q.wait_ctrl1 <= dram_pkg::WAIT_CTRL1_RST;
      q.wait_ctrl2 <= dram_pkg::WAIT_CTRL2_RST;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = !q.aw_hs && !q.bvalid;
  assign s_axi_wready = !q.w_hs && !q.bvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;

  // With no row left open, the capture cycle doubles as the next precharge.
  assign req_ready = enabled && (q.st == dram_pkg::ST_IDLE
                     || q.st == dram_pkg::ST_CAP);
  assign done = q.ack;
  assign done_rdata = q.rd;

  assign row_phase = q.st == dram_pkg::ST_PRE
                     || q.st == dram_pkg::ST_PRE_W
                     || q.st == dram_pkg::ST_ROW
                     || q.st == dram_pkg::ST_ROW_W;
  assign ras_act = q.st == dram_pkg::ST_ROW
                   || q.st == dram_pkg::ST_ROW_W
                   || q.st == dram_pkg::ST_DMA_W
                   || q.st == dram_pkg::ST_COL
                   || q.row_open;
  assign row_strobe_n = !ras_act;

  for (genvar i = 0; i < 4; i++) begin : g_lane
    // On a 16-bit bus the upper lanes never strobe.
    assign column_strobe_n[i] = !(q.st == dram_pkg::ST_COL && q.lanes[i]
                                  && (sz32 || i < 2));
  end

  assign read_strobe_n = !(!q.we && (q.st == dram_pkg::ST_COL
                          || (ext_data_out_select && q.st == dram_pkg::ST_CAP)));
  assign output_enable_n = !(ext_data_out_select && !q.we
                            && (q.st == dram_pkg::ST_COL
                                || q.st == dram_pkg::ST_CAP));
  assign rd_wr_n = !(q.we && busy);
  assign dma_acknowledge_n = !(q.dma && busy);
  // External wait logic must key off the DRAM strobes instead.
  assign bus_start_strobe_n = 1'b1;
  assign data_out = q.wd;
  assign data_oe_n = !(q.we && busy && q.st != dram_pkg::ST_PRE
                       && q.st != dram_pkg::ST_PRE_W);
endmodule : dram_space_access_controller

//--- test/dram_access_chk.sv
// Pin assertions of the DRAM space access controller.
`timescale 1ns/100ps
module dram_access_chk (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       row_strobe_n,
  input  wire logic [3:0] column_strobe_n,
  input  wire logic       output_enable_n,
  input  wire logic       rd_wr_n,
  input  wire logic       bus_start_strobe_n,
  input  wire logic       data_oe_n,
  input  wire logic       done,
  input  wire logic       s_axi_arvalid,
  input  wire logic       s_axi_arready,
  input  wire logic       s_axi_rvalid
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_bs; bus_start_strobe_n; endproperty
  a_bs: assert property (p_bs)
    else $error("Bus start strobe driven.");
  property p_cin; column_strobe_n != 4'hF |-> !row_strobe_n; endproperty
  a_cin: assert property (p_cin)
    else $error("Column strobe without row strobe.");
  property p_rfirst; $fell(row_strobe_n) |-> &column_strobe_n; endproperty
  a_rfirst: assert property (p_rfirst)
    else $error("Row and column strobes fell together.");
  property p_rc;
    $fell(row_strobe_n) |-> ##[1:7] column_strobe_n != 4'hF;
  endproperty
  a_rc: assert property (p_rc)
    else $error("Column strobe late after row strobe.");
  property p_cap; $rose(done) |-> $past(&column_strobe_n); endproperty
  a_cap: assert property (p_cap)
    else $error("Done without a capture cycle.");
  property p_oe; !output_enable_n |-> rd_wr_n; endproperty
  a_oe: assert property (p_oe)
    else $error("Output enable during a write.");
  property p_drv;
    !data_oe_n |-> !rd_wr_n && (!row_strobe_n || &column_strobe_n);
  endproperty
  a_drv: assert property (p_drv)
    else $error("Data driven outside a write.");
  property p_pulse; done |=> !done; endproperty
  a_pulse: assert property (p_pulse)
    else $error("Done longer than one cycle.");
  property p_ar; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_ar: assert property (p_ar)
    else $error("Read answer missing.");
endmodule : dram_access_chk

bind dram_space_access_controller dram_access_chk u_dram_access_chk (
  .aclk, .aresetn, .row_strobe_n, .column_strobe_n, .output_enable_n,
  .rd_wr_n, .bus_start_strobe_n, .data_oe_n, .done, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid
);

//--- test/dram_device_model.sv
// Behavioural fast page and EXT_DATA_OUT_SELECT DRAM with a board wait line.
`timescale 1ns/100ps
module dram_device_model (
  input  wire logic        aclk,
  input  wire logic [24:1] dram_addr,
  input  wire logic        row_strobe_n,
  input  wire logic [3:0]  column_strobe_n,
  input  wire logic        output_enable_n,
  input  wire logic        rd_wr_n,
  input  wire logic        slow,
  output logic      [31:0] data_in,
  output logic             ext_wait_n
);
  logic [24:1] row_q = 24'h000000;
  logic [8:1]  col_q = 8'h00;
  logic [31:0] last_q = 32'h00000000;
  logic        drive;
  logic        rs_q = 1'b1;
  // The row is the address of the first row strobe low cycle.
  always @(posedge aclk) begin
    if (!row_strobe_n && rs_q) row_q <= dram_addr;
    rs_q <= row_strobe_n;
  end
  always @* if (column_strobe_n != 4'hF) col_q = dram_addr[8:1];
  // EXT_DATA_OUT_SELECT parts keep driving while output enable stays low.
  assign drive = rd_wr_n && (column_strobe_n != 4'hF || !output_enable_n);
  // A released bus shows the inverse word, so a late capture is caught.
  assign data_in = drive ? {row_q, col_q} : ~last_q;
  always @(posedge aclk) if (drive) last_q <= data_in;
  // The board holds wait by itself; rows stay open as long as row strobe stays low.
  assign ext_wait_n = !slow;
endmodule : dram_device_model

//--- test/dram_space_access_controller_tb_top.sv
// Self-checking bench of the DRAM space access controller.
`timescale 1ns/100ps
module dram_space_access_controller_tb_top;
  localparam logic [24:0] A1 = 25'h1ABCDE4;
  localparam logic [24:0] A2 = 25'h0D5F0A8;
  logic        aclk = 1'b0, aresetn = 1'b0, slow = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, req_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF, req_byte_en = 4'hF;
  logic        req_valid = 1'b0, req_write = 1'b0, req_dma_single = 1'b0;
  logic [24:0] req_addr = 25'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, req_ready, done, row_strobe_n, read_strobe_n;
  logic        rd_wr_n, output_enable_n, dma_acknowledge_n, data_oe_n;
  logic        bus_start_strobe_n, ext_wait_n, rs_prev = 1'b1;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, done_rdata, data_out, data_in;
  logic [24:1] dram_addr;
  logic [3:0]  column_strobe_n;
  logic [31:0] dq[$];
  int          dc[$];
  int          cyc = 0, take_c = 0, failures = 0, n_tests = 0;
  int          rises = 0, up_n = 0, oe_n = 0;

  always #5 aclk = ~aclk;

  dram_space_access_controller u_dram_space_access_controller (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .req_valid, .req_ready, .req_write, .req_dma_single, .req_addr,
    .req_byte_en, .req_wdata, .done, .done_rdata, .dram_addr, .row_strobe_n,
    .column_strobe_n, .read_strobe_n, .rd_wr_n, .output_enable_n,
    .dma_acknowledge_n, .bus_start_strobe_n, .data_out, .data_oe_n,
    .data_in, .ext_wait_n
  );

  dram_device_model u_dram_device_model (
    .aclk, .dram_addr, .row_strobe_n, .column_strobe_n, .output_enable_n,
    .rd_wr_n, .slow, .data_in, .ext_wait_n
  );

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (done === 1'b1) begin
      dq.push_back(done_rdata);
      dc.push_back(cyc);
    end
    if (row_strobe_n && !rs_prev) rises++;
    rs_prev = row_strobe_n;
    if (column_strobe_n[3:2] != 2'b11) up_n++;
    if (!output_enable_n) oe_n++;
  end

  task automatic final_report();
    $display("Compares %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tmo(input logic ok);
    if (!ok) begin
      failures++;
      final_report();
    end
  endtask : tmo

  // Row pins carry the upper slice; wide columns force top pins high.
  function automatic logic [31:0] exp_rd(input logic [24:0] a, input int cw);
    logic [23:0] r;
    r = a[24:1] >> (8 + cw);
    if (cw > 1) r[14] = 1'b1;
    if (cw == 3) r[13] = 1'b1;
    return {a[24:16], r[14:0], a[8:1]};
  endfunction : exp_rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    tmo(n < 50);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tmo(n < 50);
  endtask : rd

  task automatic set_mode(input logic [9:0] v);
    wr(dram_pkg::MEM_CTRL_OFS, {22'h0, v});
  endtask : set_mode

  task automatic go(input logic [24:0] a, input logic w, input logic m);
    int n;
    req_addr <= a;
    req_write <= w;
    req_dma_single <= m;
    req_wdata <= {7'h00, a};
    req_valid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (req_ready === 1'b1) break;
    end
    tmo(n < 50);
    take_c = cyc;
  endtask : go

  task automatic wdone(input int k);
    for (int n = 0; n < 300 && dq.size() < k; n++) @(negedge aclk);
    tmo(dq.size() >= k);
  endtask : wdone

  task automatic acc(input logic [24:0] a, input logic w, input logic m,
                     output int lat, output logic [31:0] d);
    @(posedge aclk);
    go(a, w, m);
    req_valid <= 1'b0;
    wdone(1);
    d = dq.pop_front();
    lat = dc.pop_front() - take_c;
  endtask : acc

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    rd(dram_pkg::BUS_CTRL1_OFS, d, r);
    chk(d, 32'h0);
    @(negedge aclk);
    chk(req_ready, 32'h0);
    @(posedge aclk);
    rd(8'h40, d, r);
    chk(r, dram_pkg::RESP_SLVERR);
    wr(dram_pkg::BUS_CTRL1_OFS, {29'h0, dram_pkg::TYPE_DRAM});
    @(negedge aclk);
    chk(req_ready, 32'h1);
  endtask : t_regs

  task automatic t_mux();
    logic [31:0] d;
    int          lat;
    for (int cw = 0; cw < 4; cw++) begin
      // The reserved multiplex bit stays zero.
      set_mode(10'(cw << dram_pkg::MC_AMX));
      acc(A1, 1'b0, 1'b0, lat, d);
      chk(d, exp_rd(A1, cw));
      chk(lat, 32'd5);
    end
  endtask : t_mux

  task automatic lat_case(input logic [9:0] m, input logic [1:0] w3,
                          input logic [1:0] ds, input logic w,
                          input logic dma, input int e);
    logic [31:0] d;
    int          lat;
    set_mode(m);
    wr(dram_pkg::WAIT_CTRL1_OFS, {30'h0, w3});
    wr(dram_pkg::BUS_CTRL3_OFS, {30'h0, ds});
    acc(A1, w, dma, lat, d);
    chk(lat, e);
  endtask : lat_case

  task automatic t_ext();
    logic [31:0] d;
    int          lat;
    wr(dram_pkg::WAIT_CTRL1_OFS, 32'h1);
    slow <= 1'b1;
    @(posedge aclk);
    go(A1, 1'b0, 1'b0);
    req_valid <= 1'b0;
    repeat (20) @(negedge aclk);
    chk(dq.size(), 32'h0);
    @(posedge aclk);
    slow <= 1'b0;
    wdone(1);
    chk(dq.pop_front(), exp_rd(A1, 0));
    void'(dc.pop_front());
    wr(dram_pkg::WAIT_CTRL2_OFS, 32'h1);
    slow <= 1'b1;
    acc(A1, 1'b0, 1'b0, lat, d);
    chk(lat, 32'd6);
    slow <= 1'b0;
  endtask : t_ext

  task automatic t_burst();
    logic [31:0] d;
    int          lat, r0;
    set_mode(10'h000);
    // Back to back timing is judged with no programmed waits.
    wr(dram_pkg::WAIT_CTRL1_OFS, 32'h0);
    r0 = rises;
    @(posedge aclk);
    go(A1, 1'b0, 1'b0);
    go(A2, 1'b0, 1'b0);
    req_valid <= 1'b0;
    wdone(2);
    chk(dc[1] - dc[0], 32'd3);
    chk(dq[1], exp_rd(A2, 0));
    chk(rises - r0, 32'd2);
    dq.delete();
    dc.delete();
    set_mode(10'h0C0);
    acc(A1, 1'b0, 1'b0, lat, d);
    r0 = rises;
    acc(A1 + 25'h10, 1'b0, 1'b0, lat, d);
    chk(d, exp_rd(A1 + 25'h10, 0));
    chk(rises - r0, 32'd0);
    acc(A2, 1'b0, 1'b0, lat, d);
    chk(d, exp_rd(A2, 0));
    chk(rises - r0, 32'd1);
  endtask : t_burst

  task automatic t_edo();
    logic [31:0] d;
    int          lat, k;
    set_mode(10'h100);
    k = oe_n;
    acc(A1, 1'b0, 1'b0, lat, d);
    chk(d, exp_rd(A1, 0));
    chk(oe_n > k, 32'h1);
  endtask : t_edo

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_mux();
    lat_case(10'h001, 2'h0, 2'h0, 1'b0, 1'b0, 6);
    lat_case(10'h004, 2'h0, 2'h0, 1'b0, 1'b0, 7);
    lat_case(10'h000, 2'h1, 2'h0, 1'b0, 1'b0, 6);
    lat_case(10'h000, 2'h3, 2'h0, 1'b0, 1'b0, 7);
    lat_case(10'h040, 2'h1, 2'h0, 1'b0, 1'b0, 6);
    lat_case(10'h000, 2'h0, 2'h2, 1'b1, 1'b1, 7);
    lat_case(10'h000, 2'h0, 2'h2, 1'b0, 1'b1, 5);
    t_ext();
    t_burst();
    t_edo();
    chk(up_n, 32'h0);
    final_report();
  end
endmodule : dram_space_access_controller_tb_top
